// ---- hdl/cce_encoder.sv ----
// Notes on behaviour
// - Cache, TLB, generic cache code layouts
// - Memory controller and bus code layouts
// - Bit 12 marks corrected filtering active
// - Repeat corrections on a line suppressed
// - Uncorrected errors always posted
// - Transaction type: instruction, data, generic
// - Unknown transaction type reports generic
// - Level: zero, one, two, generic
// - Unknown level reports generic
// - Request sub-field nine encodings
// - Unknown action reports generic error
// - Unknown source gives generic read/write
// - Castout and snoop only in cache codes
// - Participation: originator, answerer, observer, generic
// - Time-out bit set when request timed out
// - Space: memory, I/O, other; 01 unused
// - Memory transaction codes, 101-111 unused
// - Channel number or 1111 when unknown
// - Record code and set logged flag
`timescale 1ns/1ps
module cce_encoder import cce_pkg::*; #(
    parameter int ENTRIES = CCE_TRACK_ENTRIES,
    parameter int POST_LIMIT = CCE_POST_LIMIT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Error report from detectors
    input wire logic err_valid,
    input wire cce_err_t err_info,
    // Capability strap for correction tracking
    input wire logic enh_track_en,
    // Software clear of the recorded entry
    input wire logic status_clear,
    // Recorded status
    output logic [CCE_CODE_W-1:0] status_code,
    output cce_layout_t status_layout,
    output logic entry_logged_flag,
    output logic post_pulse,
    output logic drop_pulse
);

    typedef struct packed {
        logic [CCE_CODE_W-1:0] code;
        cce_layout_t layout;
        logic logged;
        logic held_uncorr;
        logic post;
        logic drop;
    } cce_enc_state_t;

    cce_enc_state_t st_r, st_nxt;
    logic filt_post;
    logic filt_bit;

    // Transaction type from what the detector knows
    function automatic cce_txn_t txn_code(input cce_src_t s);
        case (s)
            src_insn: txn_code = txn_insn;
            src_data: txn_code = txn_data;
            default: txn_code = txn_generic;
        endcase
    endfunction

    // Hierarchy level, generic when unknown or out of range
    function automatic cce_level_t level_code(input logic known, input logic [1:0] lv);
        if (known && lv != 2'h3) begin
            level_code = cce_level_t'(lv);
        end else begin
            level_code = level_any;
        end
    endfunction

    // Request type; castout and snoop only when the layout is a cache code
    function automatic cce_req_t req_code(input cce_action_t a, input cce_src_t s,
                                          input logic cache_lay);
        case (a)
            act_read: begin
                case (s)
                    src_insn: req_code = req_insn_fetch;
                    src_data: req_code = req_data_load;
                    default: req_code = req_generic_rd;
                endcase
            end
            act_write: begin
                // There is no instruction write code, so only data is specific
                req_code = (s == src_data) ? req_data_store : req_generic_wr;
            end
            act_prefetch: req_code = req_prefetch;
            act_castout: req_code = cache_lay ? req_line_castout : req_generic_err;
            act_snoop: req_code = cache_lay ? req_snoop : req_generic_err;
            default: req_code = req_generic_err;
        endcase
    endfunction

    // Participation, generic when unknown
    function automatic cce_part_t part_code(input logic known, input logic [1:0] p);
        part_code = known ? cce_part_t'(p) : part_generic;
    endfunction

    // Space kind; the unused value folds into other transaction
    function automatic cce_space_t space_code(input logic [1:0] sp);
        space_code = (sp == 2'h1) ? space_other : cce_space_t'(sp);
    endfunction

    // Memory transaction; unused values fold into generic
    function automatic cce_memtxn_t mem_code(input logic [2:0] m);
        mem_code = (m > 3'h4) ? unspecified_mem_req : cce_memtxn_t'(m);
    endfunction

    // Channel number, or the generic value when not given
    function automatic logic [3:0] chan_code(input logic known, input logic [3:0] c);
        chan_code = (known && c <= CCE_CH_MAX) ? c : CCE_CH_GENERIC;
    endfunction

    // Assemble the full compound code for one report
    function automatic logic [CCE_CODE_W-1:0] build_code(input cce_err_t e, input logic f);
        logic [CCE_CODE_W-1:0] c;
        logic cache_lay;
        c = CCE_CODE_RST;
        cache_lay = (e.layout == lay_cache);
        c[CCE_F_BIT] = f;
        case (e.layout)
            lay_tlb: begin
                c[CCE_TLB_MARK] = 1'b1;
                c[CCE_TT_LSB +: 2] = txn_code(e.src);
                c[CCE_LL_LSB +: 2] = level_code(e.level_known, e.hier_level);
            end
            lay_memctl: begin
                c[CCE_MEM_MARK] = 1'b1;
                c[CCE_MMM_LSB +: 3] = mem_code(e.memctl_txn);
                c[CCE_CH_LSB +: 4] = chan_code(e.channel_known, e.channel_index);
            end
            lay_cache: begin
                c[CCE_CACHE_MARK] = 1'b1;
                c[CCE_RQ_LSB +: 4] = req_code(e.action, e.src, cache_lay);
                c[CCE_TT_LSB +: 2] = txn_code(e.src);
                c[CCE_LL_LSB +: 2] = level_code(e.level_known, e.hier_level);
            end
            lay_bus: begin
                c[CCE_BUS_MARK] = 1'b1;
                c[CCE_PP_LSB +: 2] = part_code(e.part_known, e.participation);
                c[CCE_T_BIT] = e.timed_out;
                c[CCE_RQ_LSB +: 4] = req_code(e.action, e.src, cache_lay);
                c[CCE_II_LSB +: 2] = space_code(e.space_kind);
                c[CCE_LL_LSB +: 2] = level_code(e.level_known, e.hier_level);
            end
            default: begin
                // Generic cache layout also absorbs any unknown layout value
                c[CCE_GEN_MARK_LSB +: 2] = CCE_GEN_MARK;
                c[CCE_LL_LSB +: 2] = level_code(e.level_known, e.hier_level);
            end
        endcase
        build_code = c;
    endfunction

    // Tracks repeated corrections per line
    cce_corr_filter #(
        .ENTRIES(ENTRIES),
        .POST_LIMIT(POST_LIMIT),
        .LINE_W(CCE_LINE_W)
    ) u_filter (
        .ref_clk(ref_clk),
        .reset(reset),
        .req_valid(err_valid),
        .req_corrected(err_info.corrected),
        .req_line(err_info.line_id),
        .track_en(enh_track_en),
        .post_ok(filt_post),
        .filt_bit(filt_bit)
    );

    // Next state: post, overwrite policy and clear
    always_comb begin
        logic keep_old;
        logic do_post;
        keep_old = 1'b0;
        do_post = 1'b0;
        st_nxt = st_r;
        st_nxt.post = 1'b0;
        st_nxt.drop = 1'b0;
        if (status_clear) begin
            st_nxt.logged = 1'b0;
            st_nxt.held_uncorr = 1'b0;
        end
        if (err_valid) begin
            // A correction does not overwrite a held uncorrected entry unless a clear comes in the same cycle
            keep_old = err_info.corrected && st_r.logged && st_r.held_uncorr && !status_clear;
            do_post = (!err_info.corrected || filt_post) && !keep_old;
            if (do_post) begin
                // Set wins over a clear in the same cycle
                st_nxt.code = build_code(err_info, err_info.corrected && filt_bit);
                st_nxt.layout = (err_info.layout > lay_bus) ? lay_gen_cache : err_info.layout;
                st_nxt.logged = 1'b1;
                st_nxt.held_uncorr = !err_info.corrected;
                st_nxt.post = 1'b1;
            end else begin
                st_nxt.drop = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '{code: CCE_CODE_RST, layout: lay_gen_cache, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign status_code = st_r.code;
    assign status_layout = st_r.layout;
    assign entry_logged_flag = st_r.logged;
    assign post_pulse = st_r.post;
    assign drop_pulse = st_r.drop;

    // Checks on the recorded code
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence s_uncorr_req;
        err_valid && !err_info.corrected;
    endsequence

    sequence s_clear_only;
        status_clear && !err_valid;
    endsequence

    a_uncorr_posted: assert property (s_uncorr_req |=> post_pulse && entry_logged_flag)
        else $error("uncorrected error not posted");

    a_uncorr_fbit: assert property (s_uncorr_req |=> !status_code[CCE_F_BIT])
        else $error("filter bit set on uncorrected error");

    a_clear_drops: assert property (s_clear_only |=> !entry_logged_flag)
        else $error("logged flag survived a clear");

    a_set_wins: assert property (s_uncorr_req and status_clear |=> entry_logged_flag)
        else $error("clear beat a new error");

    a_drop_stable: assert property (drop_pulse |-> !post_pulse && $stable(status_code))
        else $error("suppressed event changed the code");

    a_upper_zero: assert property (post_pulse |-> status_code[15:13] == 3'h0)
        else $error("upper code bits not zero");

    a_one_layout: assert property (post_pulse |-> $onehot({status_code[CCE_BUS_MARK],
        status_code[11:8] == 4'h1, status_code[11:7] == 5'h01,
        status_code[11:4] == 8'h01, status_code[11:2] == 10'h003}))
        else $error("code matches no single layout");

    a_space_valid: assert property (post_pulse && status_layout == lay_bus
        |-> status_code[CCE_II_LSB +: 2] != 2'h1)
        else $error("reserved space value recorded");

    a_memtxn_valid: assert property (post_pulse && status_layout == lay_memctl
        |-> status_code[CCE_MMM_LSB +: 3] <= 3'h4)
        else $error("reserved memory transaction recorded");

    a_castout_cache: assert property (post_pulse && status_layout == lay_bus
        |-> status_code[CCE_RQ_LSB +: 4] < 4'h7)
        else $error("castout or snoop outside cache code");

    a_generic_level: assert property (s_uncorr_req and (err_info.layout == lay_tlb
        && !err_info.level_known) |=> status_code[1:0] == 2'h3)
        else $error("unknown level not generic");

    a_generic_txn: assert property (s_uncorr_req and (err_info.layout == lay_cache
        && err_info.src == src_unknown) |=> status_code[3:2] == 2'h2)
        else $error("unknown transaction not generic");

    a_generic_read: assert property (s_uncorr_req and (err_info.layout == lay_cache
        && err_info.action == act_read && err_info.src == src_unknown)
        |=> status_code[7:4] == 4'h1)
        else $error("generic read not reported");

    a_channel_gen: assert property (s_uncorr_req and (err_info.layout == lay_memctl
        && !err_info.channel_known) |=> status_code[3:0] == 4'hF)
        else $error("unknown channel not generic");

    a_timeout_bit: assert property (s_uncorr_req and (err_info.layout == lay_bus)
        |=> status_code[CCE_T_BIT] == $past(err_info.timed_out))
        else $error("time-out bit mismatch");

    sequence s_corr_req;
        err_valid && err_info.corrected;
    endsequence

    a_report_answer: assert property (err_valid |=> post_pulse || drop_pulse)
        else $error("report got no answer");

    a_idle_quiet: assert property (!err_valid |=> !post_pulse && !drop_pulse)
        else $error("pulse without a report");

    a_post_logged: assert property (post_pulse |-> entry_logged_flag)
        else $error("posted code not flagged");

    a_plain_corr: assert property (s_corr_req
        and (!enh_track_en && !entry_logged_flag) |=> post_pulse && !status_code[CCE_F_BIT])
        else $error("untracked correction not posted plainly");

    a_tlb_mark: assert property (s_uncorr_req and (err_info.layout == lay_tlb)
        |=> status_code[11:4] == 8'h01)
        else $error("TLB layout mark wrong");

    a_cache_mark: assert property (s_uncorr_req and (err_info.layout == lay_cache)
        |=> status_code[11:8] == 4'h1)
        else $error("cache layout mark wrong");

    a_gen_mark: assert property (s_uncorr_req and (err_info.layout == lay_gen_cache)
        |=> status_code[11:2] == 10'h003)
        else $error("generic cache layout mark wrong");

    a_memctl_mark: assert property (s_uncorr_req and (err_info.layout == lay_memctl)
        |=> status_code[11:7] == 5'h01)
        else $error("memory controller layout mark wrong");

    a_bus_mark: assert property (s_uncorr_req and (err_info.layout == lay_bus)
        |=> status_code[CCE_BUS_MARK])
        else $error("bus layout mark missing");

    a_insn_txn: assert property (s_uncorr_req and (err_info.layout == lay_cache
        && err_info.src == src_insn) |=> status_code[3:2] == 2'h0)
        else $error("instruction transaction type wrong");

    a_level_copy: assert property (s_uncorr_req and (err_info.layout == lay_tlb
        && err_info.level_known && err_info.hier_level != 2'h3)
        |=> status_code[1:0] == $past(err_info.hier_level))
        else $error("known level not recorded");

    a_part_generic: assert property (s_uncorr_req and (err_info.layout == lay_bus
        && !err_info.part_known) |=> status_code[10:9] == 2'h3)
        else $error("unknown participation not generic");

    a_unknown_act: assert property (s_uncorr_req and (err_info.layout == lay_cache
        && err_info.action == act_unknown) |=> status_code[7:4] == 4'h0)
        else $error("unknown action not generic error");

    a_castout_code: assert property (s_uncorr_req and (err_info.layout == lay_cache
        && err_info.action == act_castout) |=> status_code[7:4] == 4'h7)
        else $error("castout code missing in cache layout");

    a_memtxn_copy: assert property (s_uncorr_req and (err_info.layout == lay_memctl
        && err_info.memctl_txn <= 3'h4) |=> status_code[6:4] == $past(err_info.memctl_txn))
        else $error("memory transaction not recorded");

endmodule // cce_encoder

// ---- hdl/cce_pkg.sv ----
package cce_pkg;

    // Code width and line tag width
    localparam int CCE_CODE_W = 16;
    localparam int CCE_LINE_W = 12;

    // Correction tracking sizes
    localparam int CCE_TRACK_ENTRIES = 4;
    localparam int CCE_POST_LIMIT = 3;

    // Field positions inside the compound code
    localparam int CCE_F_BIT = 12;
    localparam int CCE_BUS_MARK = 11;
    localparam int CCE_PP_LSB = 9;
    localparam int CCE_T_BIT = 8;
    localparam int CCE_CACHE_MARK = 8;
    localparam int CCE_MEM_MARK = 7;
    localparam int CCE_RQ_LSB = 4;
    localparam int CCE_MMM_LSB = 4;
    localparam int CCE_TLB_MARK = 4;
    localparam int CCE_TT_LSB = 2;
    localparam int CCE_II_LSB = 2;
    localparam int CCE_GEN_MARK_LSB = 2;
    localparam int CCE_LL_LSB = 0;
    localparam int CCE_CH_LSB = 0;

    // Fixed values and reset values
    localparam logic [1:0] CCE_GEN_MARK = 2'h3;
    localparam logic [3:0] CCE_CH_GENERIC = 4'hF;
    localparam logic [3:0] CCE_CH_MAX = 4'hE;
    localparam logic [15:0] CCE_CODE_RST = 16'h0000;

    // Code layouts
    typedef enum logic [2:0] {
        lay_gen_cache = 3'h0, lay_tlb = 3'h1, lay_memctl = 3'h2,
        lay_cache = 3'h3, lay_bus = 3'h4
    } cce_layout_t;

    // Sub-field encodings
    typedef enum logic [1:0] {txn_insn = 2'h0, txn_data = 2'h1, txn_generic = 2'h2} cce_txn_t;
    typedef enum logic [1:0] {
        level_zero = 2'h0, level_one = 2'h1, level_two = 2'h2, level_any = 2'h3
    } cce_level_t;
    typedef enum logic [3:0] {
        req_generic_err = 4'h0, req_generic_rd = 4'h1, req_generic_wr = 4'h2,
        req_data_load = 4'h3, req_data_store = 4'h4, req_insn_fetch = 4'h5,
        req_prefetch = 4'h6, req_line_castout = 4'h7, req_snoop = 4'h8
    } cce_req_t;
    typedef enum logic [1:0] {
        local_originator = 2'h0, local_answerer = 2'h1, third_party_watch = 2'h2,
        part_generic = 2'h3
    } cce_part_t;
    typedef enum logic [1:0] {space_memory = 2'h0, space_io = 2'h2, space_other = 2'h3} cce_space_t;
    typedef enum logic [2:0] {
        unspecified_mem_req = 3'h0, mem_read = 3'h1, mem_write = 3'h2,
        cmd_path_fault = 3'h3, scrub_fault = 3'h4
    } cce_memtxn_t;

    // What the detector knows about the failing access
    typedef enum logic [2:0] {
        act_unknown = 3'h0, act_read = 3'h1, act_write = 3'h2,
        act_prefetch = 3'h3, act_castout = 3'h4, act_snoop = 3'h5
    } cce_action_t;
    typedef enum logic [1:0] {src_unknown = 2'h0, src_insn = 2'h1, src_data = 2'h2} cce_src_t;

    // One error report from a detector
    typedef struct packed {
        cce_layout_t layout;
        logic corrected;
        cce_src_t src;
        cce_action_t action;
        logic level_known;
        logic [1:0] hier_level;
        logic part_known;
        logic [1:0] participation;
        logic timed_out;
        logic [1:0] space_kind;
        logic [2:0] memctl_txn;
        logic channel_known;
        logic [3:0] channel_index;
        logic [CCE_LINE_W-1:0] line_id;
    } cce_err_t;

endpackage

// ---- hdl/cce_corr_filter.sv ----
`timescale 1ns/1ps
module cce_corr_filter import cce_pkg::*; #(
    parameter int ENTRIES = CCE_TRACK_ENTRIES,
    parameter int POST_LIMIT = CCE_POST_LIMIT,
    parameter int LINE_W = CCE_LINE_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Lookup request
    input wire logic req_valid,
    input wire logic req_corrected,
    input wire logic [LINE_W-1:0] req_line,
    input wire logic track_en,
    // Verdict for the request in this cycle
    output logic post_ok,
    output logic filt_bit
);
    localparam int CNT_W = $clog2(POST_LIMIT + 1);
    localparam int PTR_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(POST_LIMIT);

    typedef struct packed {
        logic [ENTRIES-1:0] used;
        logic [ENTRIES-1:0][LINE_W-1:0] tag;
        logic [ENTRIES-1:0][CNT_W-1:0] count;
        logic [PTR_W-1:0] victim;
    } cce_filt_state_t;

    cce_filt_state_t st_r, st_nxt;

    // Search the tracked lines, then decide and update
    always_comb begin
        logic hit;
        logic [PTR_W-1:0] idx;
        logic [CNT_W-1:0] cnt_new;
        hit = 1'b0;
        idx = '0;
        cnt_new = '0;
        st_nxt = st_r;
        post_ok = 1'b1;
        filt_bit = 1'b0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (st_r.used[i] && st_r.tag[i] == req_line && !hit) begin
                hit = 1'b1;
                idx = PTR_W'(i);
            end
        end
        // Uncorrected events bypass tracking entirely
        if (req_valid && req_corrected && track_en) begin
            if (hit) begin
                if (st_r.count[idx] >= LIMIT) begin
                    post_ok = 1'b0; // Redundant correction
                end else begin
                    cnt_new = st_r.count[idx] + CNT_W'(1);
                    st_nxt.count[idx] = cnt_new;
                    filt_bit = (cnt_new == LIMIT); // Last posting for the line
                end
            end else begin
                // Round robin replacement keeps the table small and cheap
                st_nxt.used[st_r.victim] = 1'b1;
                st_nxt.tag[st_r.victim] = req_line;
                st_nxt.count[st_r.victim] = CNT_W'(1);
                st_nxt.victim = (st_r.victim == PTR_W'(ENTRIES - 1)) ? '0 :
                    st_r.victim + PTR_W'(1);
                filt_bit = (LIMIT == CNT_W'(1));
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // cce_corr_filter

// ---- verification/cce_det_model.sv ----
`timescale 1ns/1ps
module cce_det_model import cce_pkg::*; (
    // Clock
    input wire logic ref_clk,
    // Report towards the encoder
    output logic err_valid,
    output cce_err_t err_info
);

    // Idle until the first report
    initial begin
        err_valid = 1'b0;
        err_info = '0;
    end

    // One report, strobed for a single edge; the fields are then inverted
    // so the encoder cannot lean on stale values outside the strobe
    task automatic drive(input cce_err_t info);
        @(posedge ref_clk);
        err_valid <= 1'b1;
        err_info <= info;
        @(posedge ref_clk);
        err_valid <= 1'b0;
        err_info <= cce_err_t'(~info);
    endtask

endmodule // cce_det_model

// ---- verification/compound_error_code_encoder_tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module compound_error_code_encoder_tb import cce_pkg::*;;
    logic ref_clk;
    logic reset;
    logic err_valid;
    cce_err_t err_info;
    logic enh_track_en;
    logic status_clear;
    logic [CCE_CODE_W-1:0] status_code;
    cce_layout_t status_layout;
    logic entry_logged_flag;
    logic post_pulse;
    logic drop_pulse;
    int fails = 0;
    int num_checks = 0;
    cce_err_t cur;

    // Detector side
    cce_det_model u_det (.ref_clk(ref_clk), .err_valid(err_valid), .err_info(err_info));

    // Block under test
    cce_encoder #(.ENTRIES(CCE_TRACK_ENTRIES), .POST_LIMIT(CCE_POST_LIMIT)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .err_valid(err_valid), .err_info(err_info),
        .enh_track_en(enh_track_en), .status_clear(status_clear),
        .status_code(status_code), .status_layout(status_layout),
        .entry_logged_flag(entry_logged_flag), .post_pulse(post_pulse),
        .drop_pulse(drop_pulse));

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Expected transaction type for a source, worked out independently
    function automatic logic [1:0] txn_of(input cce_src_t s);
        return (s == src_insn) ? 2'h0 : (s == src_data) ? 2'h1 : 2'h2;
    endfunction

    // Fresh uncorrected report of one layout, level, participation and channel known
    task automatic base(input cce_layout_t l);
        cur = '0;
        cur.layout = l;
        cur.level_known = 1'b1;
        cur.part_known = 1'b1;
        cur.channel_known = 1'b1;
    endtask

    // Issue one report and judge the answer 1 ns after the edge that takes it
    task automatic send(input logic exp_post, input logic [15:0] exp_code);
        u_det.drive(cur);
        #1;
        `CHK(post_pulse, exp_post)
        `CHK(drop_pulse, ~exp_post)
        if (exp_post) begin
            `CHK(status_code, exp_code)
            `CHK(status_layout, cur.layout)
            `CHK(entry_logged_flag, 1'b1)
        end
    endtask

    // Software clear drops the logged flag one cycle later
    task automatic pulse_clear();
        @(posedge ref_clk);
        status_clear <= 1'b1;
        @(posedge ref_clk);
        status_clear <= 1'b0;
        #1;
        `CHK(entry_logged_flag, 1'b0)
    endtask

    // Generic cache layout over every level, then an unknown level
    task automatic t_gen_cache();
        for (int i = 0; i < 5; i++) begin
            base(lay_gen_cache);
            cur.hier_level = i[1:0];
            cur.level_known = (i < 4);
            send(1'b1, {14'h0003, (i < 4) ? i[1:0] : 2'h3});
        end
    endtask

    // TLB layout with each kind of source, the last with an unknown level
    task automatic t_tlb();
        cce_src_t s;
        logic [1:0] ll;
        for (int i = 0; i < 4; i++) begin
            s = cce_src_t'(i);
            base(lay_tlb);
            cur.src = s;
            cur.hier_level = 2'h2;
            cur.level_known = (i < 3);
            ll = (i < 3) ? 2'h2 : 2'h3;
            send(1'b1, {12'h001, txn_of(s), ll});
        end
    endtask

    // Cache layout over every request code, incl. write from an instruction
    task automatic t_cache();
        cce_action_t acts[10] = '{act_unknown, act_read, act_write, act_read, act_write,
            act_read, act_prefetch, act_castout, act_snoop, act_write};
        cce_src_t srcs[10] = '{src_data, src_unknown, src_unknown, src_data, src_data,
            src_insn, src_data, src_data, src_data, src_insn};
        logic [3:0] rq[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h2};
        for (int i = 0; i < 10; i++) begin
            base(lay_cache);
            cur.action = acts[i];
            cur.src = srcs[i];
            cur.hier_level = 2'h1;
            send(1'b1, {8'h01, rq[i], txn_of(srcs[i]), 2'h1});
        end
    endtask

    // Bus layout: castout and snoop fall back to generic error here,
    // the reserved space code is reported as other
    task automatic t_bus();
        logic [1:0] sp;
        logic [15:0] want;
        for (int i = 0; i < 4; i++) begin
            base(lay_bus);
            cur.action = (i == 0) ? act_castout : (i == 1) ? act_snoop : act_read;
            cur.src = src_data;
            cur.participation = (i == 3) ? 2'h1 : i[1:0];
            cur.part_known = (i < 3);
            cur.timed_out = i[0];
            cur.space_kind = i[1:0];
            cur.hier_level = i[1:0];
            sp = (i == 1) ? 2'h3 : i[1:0];
            want = {4'h0, 1'b1, i[1:0], i[0], (i < 2) ? 4'h0 : 4'h3, sp, i[1:0]};
            send(1'b1, want);
        end
    endtask

    // Memory controller: all transaction values, channel known and not
    task automatic t_memctl();
        logic [3:0] ch;
        logic [2:0] mt;
        for (int i = 0; i < 10; i++) begin
            base(lay_memctl);
            cur.memctl_txn = i[2:0];
            cur.channel_known = (i != 8);
            cur.channel_index = (i == 9) ? 4'hF : 4'(2 * i);
            ch = (i > 7) ? 4'hF : 4'(2 * i);
            mt = (i[2:0] > 3'h4) ? 3'h0 : i[2:0];
            send(1'b1, {8'h00, 1'b1, mt, ch});
        end
    endtask

    // Correction tracking off, then on: limit, other line, uncorrected
    task automatic t_filter();
        pulse_clear();
        base(lay_gen_cache);
        cur.corrected = 1'b1;
        cur.line_id = 12'h0B0;
        for (int i = 0; i < 4; i++) begin
            send(1'b1, 16'h000C);
        end
        @(posedge ref_clk);
        enh_track_en <= 1'b1;
        cur.line_id = 12'h0A5;
        send(1'b1, 16'h000C);
        send(1'b1, 16'h000C);
        send(1'b1, 16'h100C);
        send(1'b0, 16'h0000);
        cur.line_id = 12'h0A6;
        send(1'b1, 16'h000C);
        cur.line_id = 12'h0A5;
        cur.corrected = 1'b0;
        send(1'b1, 16'h000C);
        // A correction must not displace the held uncorrected entry
        cur.line_id = 12'h0A6;
        cur.corrected = 1'b1;
        send(1'b0, 16'h0000);
        pulse_clear();
        `CHK(status_code, 16'h000C)
        // An uncorrected report in the same cycle as a clear still sets the flag
        @(posedge ref_clk);
        status_clear <= 1'b1;
        cur.corrected = 1'b0;
        send(1'b1, 16'h000C);
        @(posedge ref_clk);
        status_clear <= 1'b0;
        #1;
        `CHK(entry_logged_flag, 1'b0)
    endtask

    // Report the counts and end the run
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        enh_track_en = 1'b0;
        status_clear = 1'b0;
        cur = '0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        `CHK(status_code, CCE_CODE_RST)
        `CHK(entry_logged_flag, 1'b0)
        t_gen_cache();
        t_tlb();
        t_cache();
        t_bus();
        t_memctl();
        t_filter();
        give_verdict();
    end

endmodule // compound_error_code_encoder_tb
